/* rtl/aer_regs_pkg.sv */
package aer_regs_pkg;
    // ***********************************
    // register offsets
    // ***********************************
    localparam logic [11:0] SEV_OFFSET = 12'hfc0;
    localparam logic [11:0] FLAGS_OFFSET = 12'hfc4;
    localparam logic [11:0] SUPPRESS_OFFSET = 12'hfc8;
    localparam logic [11:0] CAPS_OFFSET = 12'hfcc;
    // ***********************************
    // severity field layout
    // ***********************************
    localparam logic [31:0] SEV_RW_MASK = 32'h009f9030;
    localparam logic [31:0] SEV_RESET = 32'h00462030;
    localparam logic [31:0] SEV_INTERNAL_BIT = 32'h00400000;
    localparam logic [31:0] SEV_FLOWCTL_BIT = 32'h00002000;
    localparam logic [31:0] SEV_ADVISORY_MASK = 32'h00199000;
    // ***********************************
    // correctable flags and suppress layout
    // ***********************************
    localparam logic [31:0] COR_MASK = 32'h0000b1c1;
    localparam logic [31:0] COR_INTERNAL_BIT = 32'h00004000;
    localparam logic [31:0] COR_PHY_MASK = 32'h000011c1;
    localparam logic [31:0] SUP_RESET = 32'h0000a000;
    localparam logic [31:0] SUP_INTERNAL_RESET = 32'h00004000;
    localparam int ADVISORY_POS = 13;
    // ***********************************
    // uncorrectable events that cannot occur here
    // ***********************************
    localparam logic [31:0] UNC_LINK_ONLY_MASK = 32'h00000030;
    // ***********************************
    // caps and control layout
    // ***********************************
    localparam logic [4:0] FEP_RESET = 5'h1f;
    localparam int GEN_EN_POS = 6;
    localparam int CHK_EN_POS = 8;
    localparam logic [31:0] CAPS_RO_BITS = 32'h000000a0;
endpackage

/* rtl/first_error_pointer.sv */
`timescale 1ns/1ps
module first_error_pointer
    import aer_regs_pkg::*;
(
    input wire logic ref_clk_in,       // core clock
    input wire logic rstn_in,          // fundamental reset, active low
    input wire logic clk_en_in,        // freeze when low
    input wire logic [31:0] unc_in,    // unmasked, detectable events
    input wire logic [31:0] unc_status_in, // existing uncorrectable status
    output logic [4:0] fep_out         // first error position
);
    logic [4:0] fep_reg;
    logic [4:0] fep_next;
    // lowest-position event wins when several land together
    function automatic logic [4:0] low_pos(input logic [31:0] v);
        logic [4:0] p;
        p = FEP_RESET;
        for (int i = 31; i >= 0; i--) begin
            if (v[i]) begin
                p = 5'(i);
            end
        end
        return p;
    endfunction
    // first error capture: only when no status was recorded
    // masked events never reach this block
    always_comb begin
        fep_next = fep_reg;
        if ((unc_in != '0) && (unc_status_in == '0)) begin
            fep_next = low_pos(unc_in);
        end
    end
    // sticky pointer: cleared only by fundamental reset
    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            fep_reg <= FEP_RESET;
        end else if (clk_en_in) begin
            fep_reg <= fep_next;
        end
    end
    assign fep_out = fep_reg;
    // pointer holds without a fresh first event
    AST_FEP_HOLD: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
        (clk_en_in && unc_status_in != '0) |=> $stable(fep_reg))
        else $error("pointer moved after first error");
endmodule

/* rtl/sticky_flags.sv */
`timescale 1ns/1ps
module sticky_flags
    import aer_regs_pkg::*;
(
    input wire logic ref_clk_in,        // core clock
    input wire logic rstn_in,           // fundamental reset, active low
    input wire logic clk_en_in,         // freeze when low
    input wire logic [31:0] impl_in,    // implemented bit positions
    input wire logic [31:0] set_in,     // detection pulses
    input wire logic wr_in,             // write strobe
    input wire logic [31:0] wdata_in,   // write data
    input wire logic force_in,          // plain read-write mode
    output logic [31:0] flags_out       // current flags
);
    logic [31:0] flags_reg;
    logic [31:0] flags_next;
    genvar g;
    // per-bit next value; detection wins over any write in the same cycle
    generate
        for (g = 0; g < 32; g++) begin : g_bit
            always_comb begin
                flags_next[g] = flags_reg[g];
                if (!impl_in[g]) begin
                    flags_next[g] = 1'b0;
                end else if (set_in[g]) begin
                    flags_next[g] = 1'b1;
                end else if (wr_in && force_in) begin
                    flags_next[g] = wdata_in[g];
                end else if (wr_in && wdata_in[g]) begin
                    flags_next[g] = 1'b0;
                end
            end
        end
    endgenerate
    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            flags_reg <= '0;
        end else if (clk_en_in) begin
            flags_reg <= flags_next;
        end
    end
    assign flags_out = flags_reg;
    // a set flag stays set without a clearing write
    AST_FLAG_STICKY: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
        (clk_en_in && !wr_in) |=> ((flags_reg & $past(flags_reg & impl_in)) == $past(flags_reg & impl_in)))
        else $error("flag lost");
    AST_FLAG_SET: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
        (clk_en_in && !wr_in && (set_in & impl_in) != '0) |=> ((flags_reg & $past(set_in & impl_in)) != '0))
        else $error("detection not latched");
endmodule

/* rtl/aer_severity_correctable_ctrl.sv */
`timescale 1ns/1ps
module aer_severity_correctable_ctrl
    import aer_regs_pkg::*;
(
    input wire logic ref_clk_in,            // core clock, 10 MHz
    input wire logic rstn_in,               // fundamental reset, active low
    input wire logic clk_en_in,             // freeze all state when low
    input wire logic soft_rstn_in,          // other reset, non-sticky only, active low
    input wire logic port0_nt_in,           // port 0 is non_transparent
    input wire logic legacy_nt_in,          // legacy non_transparent mode
    input wire logic force_err_in,          // software force-error enable
    input wire logic cfg_wr_in,             // register write strobe
    input wire logic cfg_rd_in,             // register read strobe
    input wire logic [11:0] cfg_addr_in,    // register byte offset
    input wire logic [31:0] cfg_wdata_in,   // write data
    input wire logic [3:0] cfg_be_in,       // byte enables
    input wire logic [31:0] cor_detect_in,  // correctable detection pulses
    input wire logic [31:0] unc_detect_in,  // uncorrectable detection pulses
    input wire logic [31:0] unc_mask_in,    // uncorrectable mask bits
    input wire logic [31:0] unc_status_in,  // uncorrectable status bits
    output logic [31:0] cfg_rdata_out,      // read data
    output logic cfg_hit_out,               // address hit this cycle
    output logic [31:0] unc_report_out,     // unmasked events to record
    output logic fatal_out,                 // fatal error reported
    output logic nonfatal_out,              // non-fatal error reported
    output logic cor_report_out,            // correctable error reported
    output logic ecrc_gen_en_out,           // crc generation on
    output logic ecrc_chk_en_out,           // crc checking on
    output logic [4:0] fep_out              // first error pointer
);
    // ***********************************
    // state
    // ***********************************
    logic [31:0] sev_reg;      // severity
    logic [31:0] sev_next;
    logic [31:0] sup_reg;      // suppress
    logic [31:0] sup_next;
    logic gen_en_reg;          // crc generation enable
    logic gen_en_next;
    logic chk_en_reg;          // crc check enable
    logic chk_en_next;
    logic [31:0] rdata_reg;    // registered read data
    logic [31:0] rdata_next;
    logic fatal_r;
    logic nonfatal_r;
    logic cor_r;
    logic [31:0] unc_rep_reg;
    logic [31:0] cor_flags;
    logic [31:0] cor_impl;
    logic [31:0] cor_set;
    logic [31:0] sev_wmask;
    logic [31:0] wr_bytes;
    logic [31:0] unc_live;
    logic [31:0] sev_view;
    logic wr_sev;
    logic wr_flags;
    logic wr_sup;
    logic wr_caps;
    logic adv_hit;

    // byte enables expand to a bit mask
    function automatic logic [31:0] be_mask(input logic [3:0] be);
        return {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    endfunction

    // ***********************************
    // address decode
    // ***********************************
    always_comb begin
        wr_sev = 1'b0;
        wr_flags = 1'b0;
        wr_sup = 1'b0;
        wr_caps = 1'b0;
        if (cfg_addr_in == SEV_OFFSET) begin
            wr_sev = cfg_wr_in;
        end else if (cfg_addr_in == FLAGS_OFFSET) begin
            wr_flags = cfg_wr_in;
        end else if (cfg_addr_in == SUPPRESS_OFFSET) begin
            wr_sup = cfg_wr_in;
        end else if (cfg_addr_in == CAPS_OFFSET) begin
            wr_caps = cfg_wr_in;
        end
    end
    assign cfg_hit_out = (cfg_addr_in == SEV_OFFSET) || (cfg_addr_in == FLAGS_OFFSET) ||
                         (cfg_addr_in == SUPPRESS_OFFSET) || (cfg_addr_in == CAPS_OFFSET);
    assign wr_bytes = be_mask(cfg_be_in);

    // ***********************************
    // severity
    // ***********************************
    // internal bit writable only with port 0 non_transparent
    assign sev_wmask = port0_nt_in ? (SEV_RW_MASK | SEV_INTERNAL_BIT) : SEV_RW_MASK;
    // reserved positions read fixed values; internal reads 1 if reserved
    assign sev_view = (sev_reg & sev_wmask) | SEV_FLOWCTL_BIT | (port0_nt_in ? 32'h0 : SEV_INTERNAL_BIT);
    always_comb begin
        sev_next = sev_reg;
        if (wr_sev) begin
            sev_next = (sev_reg & ~(sev_wmask & wr_bytes)) | (cfg_wdata_in & sev_wmask & wr_bytes);
        end
    end

    // ***********************************
    // suppress
    // ***********************************
    // bit 14 exists only in legacy mode
    assign cor_impl = legacy_nt_in ? (COR_MASK | COR_INTERNAL_BIT) : COR_MASK;
    always_comb begin
        sup_next = sup_reg;
        if (wr_sup) begin
            sup_next = (sup_reg & ~(cor_impl & wr_bytes)) | (cfg_wdata_in & cor_impl & wr_bytes);
        end
    end

    // ***********************************
    // caps and control
    // ***********************************
    always_comb begin
        gen_en_next = gen_en_reg;
        chk_en_next = chk_en_reg;
        if (wr_caps && cfg_be_in[0]) begin
            gen_en_next = cfg_wdata_in[GEN_EN_POS];
        end
        if (wr_caps && cfg_be_in[1]) begin
            chk_en_next = cfg_wdata_in[CHK_EN_POS];
        end
    end

    // ***********************************
    // error classification
    // ***********************************
    // link-only events are dropped; masked events go nowhere
    assign unc_live = unc_detect_in & ~UNC_LINK_ONLY_MASK & ~unc_mask_in & sev_wmask;
    // advisory errors with severity 0 become correctable
    assign adv_hit = (unc_live & SEV_ADVISORY_MASK & ~sev_reg) != '0;
    // physical-link correctable events never detected here
    always_comb begin
        cor_set = cor_detect_in & ~COR_PHY_MASK & cor_impl;
        cor_set[ADVISORY_POS] = cor_set[ADVISORY_POS] | adv_hit;
    end

    // ***********************************
    // read mux
    // ***********************************
    always_comb begin
        rdata_next = '0;
        if (!cfg_rd_in) begin
            rdata_next = rdata_reg;
        end else if (cfg_addr_in == SEV_OFFSET) begin
            rdata_next = sev_view;
        end else if (cfg_addr_in == FLAGS_OFFSET) begin
            rdata_next = cor_flags & cor_impl;
        end else if (cfg_addr_in == SUPPRESS_OFFSET) begin
            rdata_next = sup_reg & cor_impl;
        end else if (cfg_addr_in == CAPS_OFFSET) begin
            rdata_next = CAPS_RO_BITS | {27'h0, fep_out};
            rdata_next[GEN_EN_POS] = gen_en_reg;
            rdata_next[CHK_EN_POS] = chk_en_reg;
        end
    end

    // ***********************************
    // sticky registers (fundamental reset only)
    // ***********************************
    // sticky reset values
    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            sev_reg <= SEV_RESET;
            sup_reg <= SUP_RESET | SUP_INTERNAL_RESET;
            gen_en_reg <= 1'b0;
            chk_en_reg <= 1'b0;
        end else if (clk_en_in) begin
            sev_reg <= sev_next;
            sup_reg <= sup_next;
            gen_en_reg <= gen_en_next;
            chk_en_reg <= chk_en_next;
        end
    end

    // ***********************************
    // non-sticky outputs (cleared by either reset)
    // ***********************************
    // soft reset is synchronous: only read data, the event report and report strobes fall
    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            rdata_reg <= '0;
            fatal_r <= 1'b0;
            nonfatal_r <= 1'b0;
            cor_r <= 1'b0;
            unc_rep_reg <= '0;
        end else if (clk_en_in) begin
            if (!soft_rstn_in) begin
                rdata_reg <= '0;
                fatal_r <= 1'b0;
                nonfatal_r <= 1'b0;
                cor_r <= 1'b0;
                unc_rep_reg <= '0;
            end else begin
                rdata_reg <= rdata_next;
                fatal_r <= (unc_live & sev_reg) != '0;
                nonfatal_r <= (unc_live & ~sev_reg & ~SEV_ADVISORY_MASK) != '0;
                cor_r <= (cor_set & ~sup_reg) != '0;
                unc_rep_reg <= unc_live;
            end
        end
    end

    // ***********************************
    // submodules
    // ***********************************
    sticky_flags u_flags (
        .ref_clk_in(ref_clk_in),
        .rstn_in(rstn_in),
        .clk_en_in(clk_en_in),
        .impl_in(cor_impl),
        .set_in(cor_set),
        .wr_in(wr_flags),
        .wdata_in(cfg_wdata_in & wr_bytes),
        .force_in(force_err_in),
        .flags_out(cor_flags)
    );
    first_error_pointer u_fep (
        .ref_clk_in(ref_clk_in),
        .rstn_in(rstn_in),
        .clk_en_in(clk_en_in),
        .unc_in(unc_live),
        .unc_status_in(unc_status_in),
        .fep_out(fep_out)
    );

    assign cfg_rdata_out = rdata_reg;
    assign unc_report_out = unc_rep_reg;
    assign fatal_out = fatal_r;
    assign nonfatal_out = nonfatal_r;
    assign cor_report_out = cor_r;
    assign ecrc_gen_en_out = gen_en_reg;
    assign ecrc_chk_en_out = chk_en_reg;

    // ***********************************
    // checks
    // ***********************************
    sequence s_sev_write;
        clk_en_in && wr_sev && (cfg_be_in == 4'hf);
    endsequence
    AST_SEV_FATAL: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
        (clk_en_in && soft_rstn_in && ((unc_live & sev_reg) != '0)) |=> fatal_out)
        else $error("fatal not reported");
    AST_ADVISORY: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
        (clk_en_in && soft_rstn_in && adv_hit && !sup_reg[ADVISORY_POS]) |=> cor_report_out)
        else $error("advisory not reported as correctable");
    AST_INTERNAL_LOCK: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
        (s_sev_write and !port0_nt_in) |=> $stable(sev_reg[22]))
        else $error("internal severity written while reserved");
    AST_FLOWCTL_ONE: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
        sev_view[13] && !sev_view[14])
        else $error("reserved severity reads wrong");
    AST_NO_PHY: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
        (cor_set & COR_PHY_MASK) == '0)
        else $error("physical error detected on virtual side");
    AST_NO_LINKONLY: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
        (unc_live & UNC_LINK_ONLY_MASK) == '0)
        else $error("link-only uncorrectable detected");
    AST_SUPPRESS: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
        (clk_en_in && soft_rstn_in && ((cor_set & ~sup_reg) == '0)) |=> !cor_report_out)
        else $error("suppressed error reported");
    AST_MASKED: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
        (clk_en_in && soft_rstn_in) |=> ((unc_report_out & $past(unc_mask_in)) == '0))
        else $error("masked error reported");
    AST_GEN_EN: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
        (clk_en_in && wr_caps && cfg_be_in[0]) |=> (ecrc_gen_en_out == $past(cfg_wdata_in[GEN_EN_POS])))
        else $error("crc generation enable not written");
    AST_CHK_EN: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
        (clk_en_in && wr_caps && cfg_be_in[1]) |=> (ecrc_chk_en_out == $past(cfg_wdata_in[CHK_EN_POS])))
        else $error("crc check enable not written");
    AST_NONFATAL: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
        (clk_en_in && soft_rstn_in && ((unc_live & ~sev_reg & ~SEV_ADVISORY_MASK) != '0)) |=> nonfatal_out)
        else $error("non-fatal not reported");
    AST_SEV_RESERVED: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
        (sev_view & ~(SEV_RW_MASK | SEV_INTERNAL_BIT | SEV_FLOWCTL_BIT)) == '0)
        else $error("reserved severity bit reads one");
    AST_FORCE_WRITE: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
        (clk_en_in && wr_flags && force_err_in && cfg_be_in == 4'hf && cor_set == '0) |=>
        (cor_flags == $past(cfg_wdata_in & cor_impl)))
        else $error("forced flag write not taken");
    // read requests whose data stands on the next edge; a stale or
    // misplaced field would slip past software unnoticed
    sequence s_flags_read;
        clk_en_in && soft_rstn_in && cfg_rd_in && (cfg_addr_in == FLAGS_OFFSET);
    endsequence
    sequence s_caps_read;
        clk_en_in && soft_rstn_in && cfg_rd_in && (cfg_addr_in == CAPS_OFFSET);
    endsequence
    AST_COR_RESERVED: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
        (s_flags_read ##0 !legacy_nt_in) |=> ((cfg_rdata_out & ~COR_MASK) == '0))
        else $error("unimplemented flag reads one");
    AST_CAPS_RO: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
        s_caps_read |=> ((cfg_rdata_out & CAPS_RO_BITS) == CAPS_RO_BITS))
        else $error("crc capability bits read zero");
    AST_FEP_READ: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
        s_caps_read |=> (5'(cfg_rdata_out) == $past(fep_out)))
        else $error("pointer field reads wrong");
    AST_RD_UNMAPPED: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
        (clk_en_in && soft_rstn_in && cfg_rd_in && !cfg_hit_out) |=> (cfg_rdata_out == '0))
        else $error("unmapped read returned data");
    AST_SOFT_KEEP: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
        (clk_en_in && !soft_rstn_in && !wr_sev) |=> $stable(sev_reg))
        else $error("soft reset disturbed sticky severity");
endmodule

/* sim/tb_aer_severity_correctable_ctrl.sv */
`timescale 1ns/1ps
module tb_aer_severity_correctable_ctrl;
    import aer_regs_pkg::*;
    // ********
    // stimulus and observed signals
    // ********
    logic ref_clk_in = 1'b0, rstn_in = 1'b0, clk_en_in = 1'b1, soft_rstn_in = 1'b1;
    logic port0_nt_in = 1'b0, legacy_nt_in = 1'b0, force_err_in = 1'b0, cfg_wr_in = 1'b0, cfg_rd_in = 1'b0;
    logic [11:0] cfg_addr_in = 12'h000;
    logic [31:0] cfg_wdata_in = 32'h0, cor_detect_in = 32'h0, unc_detect_in = 32'h0, unc_mask_in = 32'h0;
    logic [31:0] unc_status_in = 32'h1; // nonzero keeps the pointer still
    logic [3:0] cfg_be_in = 4'hf;
    logic [31:0] cfg_rdata_out, unc_report_out;
    logic cfg_hit_out, fatal_out, nonfatal_out, cor_report_out, ecrc_gen_en_out, ecrc_chk_en_out;
    logic [4:0] fep_out;
    int err_count = 0, comparisons = 0, cycles = 0;
    logic rd_pend = 1'b0, ev_pend = 1'b0; // a result is due this cycle
    logic [31:0] rd_q[$], rep_q[$]; // expected read data and event reports
    logic [2:0] pulse_q[$]; // expected fatal, nonfatal, correctable
    logic [31:0] sev; // severity written this round
    logic adv;

    aer_severity_correctable_ctrl DUT (.ref_clk_in(ref_clk_in), .rstn_in(rstn_in), .clk_en_in(clk_en_in),
        .soft_rstn_in(soft_rstn_in), .port0_nt_in(port0_nt_in), .legacy_nt_in(legacy_nt_in),
        .force_err_in(force_err_in), .cfg_wr_in(cfg_wr_in), .cfg_rd_in(cfg_rd_in), .cfg_addr_in(cfg_addr_in),
        .cfg_wdata_in(cfg_wdata_in), .cfg_be_in(cfg_be_in), .cor_detect_in(cor_detect_in),
        .unc_detect_in(unc_detect_in), .unc_mask_in(unc_mask_in), .unc_status_in(unc_status_in),
        .cfg_rdata_out(cfg_rdata_out), .cfg_hit_out(cfg_hit_out), .unc_report_out(unc_report_out),
        .fatal_out(fatal_out), .nonfatal_out(nonfatal_out), .cor_report_out(cor_report_out),
        .ecrc_gen_en_out(ecrc_gen_en_out), .ecrc_chk_en_out(ecrc_chk_en_out), .fep_out(fep_out));

    // 10 MHz clock
    always #50 ref_clk_in = ~ref_clk_in;

    // ********
    // compare and closing tasks
    // ********
    task automatic cmp32(input logic [31:0] got, input logic [31:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic cmp3(input logic [2:0] got, input logic [2:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: pulses got %b expected %b", $time, got, exp);
        end
    endtask

    task automatic end_of_test();
        $display("comparisons %0d err_count %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // a hang counts as a mismatch
    always @(posedge ref_clk_in) begin
        cycles++;
        if (cycles == 20000) begin
            err_count++;
            end_of_test();
        end
    end

    // ********
    // result watcher: results land on the same edge that takes the request
    // ********
    always @(posedge ref_clk_in) begin
        rd_pend <= cfg_rd_in & clk_en_in;
        ev_pend <= |unc_detect_in;
    end

    // compare at the falling edge, where registered outputs are settled
    always @(negedge ref_clk_in) begin
        if (rd_pend && rd_q.size() > 0) begin
            cmp32(cfg_rdata_out, rd_q.pop_front(), "read data");
        end
        if (ev_pend && pulse_q.size() > 0) begin
            cmp3({fatal_out, nonfatal_out, cor_report_out}, pulse_q.pop_front());
            cmp32(unc_report_out, rep_q.pop_front(), "event report");
        end
    end

    // ********
    // drivers: change just after the rising edge
    // ********
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] be);
        @(posedge ref_clk_in);
        #1;
        cfg_addr_in = a;
        cfg_wdata_in = d;
        cfg_be_in = be;
        cfg_wr_in = 1'b1;
        @(posedge ref_clk_in);
        #1;
        cfg_wr_in = 1'b0;
    endtask

    // read; the hit flag is combinational so it is checked while the address stands
    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        @(posedge ref_clk_in);
        #1;
        rd_q.push_back(exp);
        cfg_addr_in = a;
        cfg_rd_in = 1'b1;
        #1;
        cmp32({31'h0, cfg_hit_out}, {31'h0, a inside {12'hfc0, 12'hfc4, 12'hfc8, 12'hfcc}}, "hit");
        @(posedge ref_clk_in);
        #1;
        cfg_rd_in = 1'b0;
    endtask

    // one-cycle uncorrectable detection pulse
    task automatic ev(input logic [31:0] det, input logic [2:0] pulses, input logic [31:0] rep);
        @(posedge ref_clk_in);
        #1;
        pulse_q.push_back(pulses);
        rep_q.push_back(rep);
        unc_detect_in = det;
        @(posedge ref_clk_in);
        #1;
        unc_detect_in = 32'h0;
    endtask

    // ********
    // main sequence
    // ********
    initial begin
        void'($urandom(95417));
        repeat (8) @(posedge ref_clk_in);
        #1;
        rstn_in = 1'b1;
        rd(SEV_OFFSET, SEV_RESET);
        rd(FLAGS_OFFSET, 32'h0);
        rd(SUPPRESS_OFFSET, SUP_RESET);
        legacy_nt_in = 1'b1;
        rd(SUPPRESS_OFFSET, SUP_RESET | SUP_INTERNAL_RESET);
        rd(CAPS_OFFSET, {27'h0, FEP_RESET} | CAPS_RO_BITS);
        rd(12'hfd0, 32'h0);
        // reserved severity positions hold their fixed values
        wr(SEV_OFFSET, 32'hffffffff, 4'hf);
        rd(SEV_OFFSET, SEV_RW_MASK | SEV_INTERNAL_BIT | SEV_FLOWCTL_BIT);
        wr(SEV_OFFSET, 32'h0, 4'hf);
        rd(SEV_OFFSET, SEV_INTERNAL_BIT | SEV_FLOWCTL_BIT);
        wr(SEV_OFFSET, 32'hffffffff, 4'h2);
        rd(SEV_OFFSET, SEV_INTERNAL_BIT | SEV_FLOWCTL_BIT | 32'h00009000);
        port0_nt_in = 1'b1;
        wr(SEV_OFFSET, 32'h0, 4'hf);
        rd(SEV_OFFSET, SEV_FLOWCTL_BIT);
        // a frozen block ignores the write
        clk_en_in = 1'b0;
        wr(SEV_OFFSET, 32'hffffffff, 4'hf);
        clk_en_in = 1'b1;
        rd(SEV_OFFSET, SEV_FLOWCTL_BIT);
        // random severities, every implemented position pulsed in turn
        wr(SUPPRESS_OFFSET, 32'h0, 4'hf);
        for (int n = 0; n < 4; n++) begin
            sev = $urandom() & (SEV_RW_MASK | SEV_INTERNAL_BIT);
            wr(SEV_OFFSET, sev, 4'hf);
            rd(SEV_OFFSET, sev | SEV_FLOWCTL_BIT);
            for (int b = 0; b < 24; b++) begin
                adv = SEV_ADVISORY_MASK[b];
                if (UNC_LINK_ONLY_MASK[b]) begin
                    ev(32'h1 << b, 3'b000, 32'h0);
                end else if ((SEV_RW_MASK | SEV_INTERNAL_BIT) & (32'h1 << b)) begin
                    ev(32'h1 << b, {sev[b], !sev[b] && !adv, !sev[b] && adv}, 32'h1 << b);
                end
            end
        end
        // suppressed advisory still flags but does not report
        wr(FLAGS_OFFSET, 32'hffffffff, 4'hf);
        wr(SEV_OFFSET, SEV_RESET, 4'hf);
        wr(SUPPRESS_OFFSET, 32'h00002000, 4'hf);
        ev(32'h00001000, 3'b000, 32'h00001000);
        rd(FLAGS_OFFSET, 32'h00002000);
        // physical-link detections never land on the virtual side
        @(posedge ref_clk_in);
        #1;
        cor_detect_in = COR_MASK | COR_INTERNAL_BIT;
        @(posedge ref_clk_in);
        #1;
        cor_detect_in = 32'h0;
        rd(FLAGS_OFFSET, 32'h0000e000);
        wr(FLAGS_OFFSET, 32'h00004000, 4'hf);
        rd(FLAGS_OFFSET, 32'h0000a000);
        force_err_in = 1'b1;
        wr(FLAGS_OFFSET, 32'hffffffff, 4'hf);
        rd(FLAGS_OFFSET, COR_MASK | COR_INTERNAL_BIT);
        force_err_in = 1'b0;
        wr(FLAGS_OFFSET, 32'h00000040, 4'hf);
        rd(FLAGS_OFFSET, (COR_MASK | COR_INTERNAL_BIT) & ~32'h40);
        // masked event leaves the pointer; lowest live bit is recorded
        unc_status_in = 32'h0;
        unc_mask_in = 32'h00001000;
        ev(32'h00041000, 3'b100, 32'h00040000);
        unc_status_in = 32'h00040000;
        cmp32({27'h0, fep_out}, 32'h00000012, "pointer");
        rd(CAPS_OFFSET, CAPS_RO_BITS | 32'h12);
        wr(CAPS_OFFSET, 32'hffffffff, 4'hf);
        rd(CAPS_OFFSET, 32'h000001f2);
        cmp32({30'h0, ecrc_gen_en_out, ecrc_chk_en_out}, 32'h3, "crc enables");
        // soft reset keeps sticky state
        soft_rstn_in = 1'b0;
        repeat (2) @(posedge ref_clk_in);
        #1;
        soft_rstn_in = 1'b1;
        rd(SEV_OFFSET, SEV_RESET);
        wr(CAPS_OFFSET, 32'h0, 4'h1);
        rd(CAPS_OFFSET, 32'h000001b2);
        cmp32({30'h0, ecrc_gen_en_out, ecrc_chk_en_out}, 32'h1, "crc enables");
        // fundamental reset in mid-run, once the last read is compared
        @(posedge ref_clk_in);
        #1;
        rstn_in = 1'b0;
        repeat (2) @(posedge ref_clk_in);
        #1;
        rstn_in = 1'b1;
        rd(CAPS_OFFSET, {27'h0, FEP_RESET} | CAPS_RO_BITS);
        rd(FLAGS_OFFSET, 32'h0);
        repeat (2) @(posedge ref_clk_in);
        end_of_test();
    end
endmodule
